// File: rtl/parallel_io_port_block.v
// Register access over AXI4-Lite was decided locally.
`include "pio_map.vh"
`default_nettype none
module parallel_io_port_block (
    // Clock, reset, enable
    input wire aclk,
    input wire aresetn,
    input wire clk_en,
    // AXI4-Lite write
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Pins, six ports of eight, index port*8+bit (A..F)
    input wire [47:0] pin_in,
    output reg [47:0] pin_out,
    output reg [47:0] pin_oe,
    // Peripheral alternate functions
    input wire [47:0] alt_out_en,
    input wire [47:0] alt_out_val,
    input wire [47:0] alt_out_od,
    output reg [47:0] alt_in,
    // External interrupt lines for ports A, C, D
    output reg [23:0] ext_int_level,
    // Port C high-sink pin map
    output reg [7:0] c_high_sink,
    // Interrupt
    output reg irq
);

// ============================================================
// Port registers
reg [7:0] latch_q [0:5];
reg [7:0] dir_q [0:5];
reg [7:0] opt_q [0:5];
reg [47:0] pin_s_q;
reg [3:0] irq_stat_q;
reg [3:0] irq_mask_q;
reg [23:0] int_prev_q;

// ============================================================
// Write channel state
reg aw_hold_q;
reg w_hold_q;
reg [4:0] aw_idx_q;
reg [7:0] w_byte_q;
reg w_lane_q;
wire do_write;
assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
wire [2:0] wport;
wire [1:0] wkind;
wire wmap;
reg [2:0] port_r;
reg [1:0] kind_r;
reg map_r;

// Decode index into port and kind (0 latch, 1 dir, 2 opt)
function [5:0] decode;
    input [4:0] idx;
    begin
        case (idx)
            `IDX_A_LATCH: decode = {1'b1, 3'd0, 2'd0};
            `IDX_A_DIR: decode = {1'b1, 3'd0, 2'd1};
            `IDX_A_OPT: decode = {1'b1, 3'd0, 2'd2};
            `IDX_B_LATCH: decode = {1'b1, 3'd1, 2'd0};
            `IDX_B_DIR: decode = {1'b1, 3'd1, 2'd1};
            `IDX_C_LATCH: decode = {1'b1, 3'd2, 2'd0};
            `IDX_C_DIR: decode = {1'b1, 3'd2, 2'd1};
            `IDX_C_OPT: decode = {1'b1, 3'd2, 2'd2};
            `IDX_D_LATCH: decode = {1'b1, 3'd3, 2'd0};
            `IDX_D_DIR: decode = {1'b1, 3'd3, 2'd1};
            `IDX_D_OPT: decode = {1'b1, 3'd3, 2'd2};
            `IDX_E_LATCH: decode = {1'b1, 3'd4, 2'd0};
            `IDX_E_DIR: decode = {1'b1, 3'd4, 2'd1};
            `IDX_E_OPT: decode = {1'b1, 3'd4, 2'd2};
            `IDX_F_LATCH: decode = {1'b1, 3'd5, 2'd0};
            `IDX_F_DIR: decode = {1'b1, 3'd5, 2'd1};
            default: decode = 6'h00;
        endcase
    end
endfunction

assign {wmap, wport, wkind} = decode(aw_idx_q);

// ============================================================
// Per-pin configuration
wire [47:0] drive_oe;
wire [47:0] drive_val;
wire [47:0] read_val;
wire [23:0] int_lvl;

genvar g;
generate
    for (g = 0; g < 48; g = g + 1) begin : pin_g
        localparam P = g / 8;
        localparam B = g % 8;
        localparam HAS_OPT = (P == 0) || (P == 2) || (P == 3) || (P == 4);
        wire dirb = dir_q[P][B];
        wire optb = HAS_OPT ? opt_q[P][B] : 1'b0;
        wire latb = latch_q[P][B];
        wire alt = alt_out_en[g];
        wire od;
        wire val;
        // Output style per port
        if (P == 1) begin : pb
            assign od = 1'b0;
        end else if (P == 2) begin : pc
            assign od = 1'b0;
        end else if (P == 5) begin : pf
            // Fixed push-pull pins, the rest true open drain
            localparam [7:0] FPP = `F_PUSH_PULL;
            assign od = !FPP[B];
        end else begin : po
            assign od = !optb;
        end
        // Peripheral overrides port programming
        assign val = alt ? alt_out_val[g] : latb;
        wire od_eff = alt ? (alt_out_od[g] | (P == 5 && od)) : od;
        wire outm = alt | dirb;
        // Open drain drives low only
        assign drive_oe[g] = outm && (od_eff ? !val : 1'b1);
        assign drive_val[g] = outm && val;
        // Input with alt output reads alt state
        assign read_val[g] = (!dirb && alt) ? alt_out_val[g] : pin_s_q[g];
        if (P == 0 || P == 2 || P == 3) begin : ig
            localparam I = (P == 0) ? B : ((P == 2) ? 8 + B : 16 + B);
            // Interrupt only when floating input with interrupt
            assign int_lvl[I] = (!dirb && optb && !alt) ? pin_s_q[g] : 1'b0;
        end
    end
endgenerate

// ============================================================
// Read mux
reg [7:0] rd_byte;
reg rd_ok;
always @* begin
    {map_r, port_r, kind_r} = decode(s_axi_araddr[6:2]);
    rd_byte = 8'h00;
    rd_ok = 1'b1;
    if (map_r) begin
        case (kind_r)
            2'd0: rd_byte = read_val[port_r*8 +: 8];
            2'd1: rd_byte = dir_q[port_r];
            default: rd_byte = opt_q[port_r];
        endcase
    end else if (s_axi_araddr[6:2] == `IDX_IRQ_STAT) begin
        rd_byte = {4'h0, irq_stat_q};
    end else if (s_axi_araddr[6:2] == `IDX_IRQ_MASK) begin
        rd_byte = {4'h0, irq_mask_q};
    end else begin
        rd_ok = 1'b0;
    end
    if (s_axi_araddr[7]) begin
        rd_ok = 1'b0;
        rd_byte = 8'h00;
    end
end

// ============================================================
// Interrupt events: any rising edge of a forwarded level per port group
wire [3:0] evt;
assign evt = {1'b0,
    |(int_lvl[23:16] & ~int_prev_q[23:16]),
    |(int_lvl[15:8] & ~int_prev_q[15:8]),
    |(int_lvl[7:0] & ~int_prev_q[7:0])};

// ============================================================
// Main clocked process
integer i;
always @(posedge aclk) begin
    if (!aresetn) begin
        for (i = 0; i < 6; i = i + 1) begin
            latch_q[i] <= `REG_RESET;
            dir_q[i] <= `REG_RESET;
            opt_q[i] <= `REG_RESET;
        end
        pin_s_q <= 48'h0;
        irq_stat_q <= `IRQ_RESET;
        irq_mask_q <= `IRQ_RESET;
        int_prev_q <= 24'h0;
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        aw_idx_q <= 5'h00;
        w_byte_q <= 8'h00;
        w_lane_q <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `RESP_OKAY;
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rresp <= `RESP_OKAY;
        s_axi_rdata <= 32'h0;
        pin_out <= 48'h0;
        pin_oe <= 48'h0;
        alt_in <= 48'h0;
        ext_int_level <= 24'h0;
        c_high_sink <= 8'h00;
        irq <= 1'b0;
    end else if (clk_en) begin
        // Pin sampling and outputs
        pin_s_q <= pin_in;
        pin_out <= drive_val;
        pin_oe <= drive_oe;
        // Output pins feed latch to peripheral inputs
        for (i = 0; i < 48; i = i + 1) begin
            alt_in[i] <= dir_q[i/8][i%8] ? latch_q[i/8][i%8] : pin_s_q[i];
        end
        ext_int_level <= int_lvl;
        int_prev_q <= int_lvl;
        c_high_sink <= `C_HIGH_SINK;
        // Write address and data, taken in either order
        s_axi_awready <= !aw_hold_q && !s_axi_awready;
        s_axi_wready <= !w_hold_q && !s_axi_wready;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            aw_idx_q <= s_axi_awaddr[6:2];
            w_lane_q <= s_axi_awaddr[7];
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            w_byte_q <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
            s_axi_wready <= 1'b0;
            if (!s_axi_wstrb[0]) begin
                w_lane_q <= w_lane_q;
            end
        end
        // Status set wins over write-one-to-clear
        irq_stat_q <= irq_stat_q | evt;
        if (do_write) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `RESP_OKAY;
            if (w_lane_q) begin
                s_axi_bresp <= `RESP_SLVERR;
            end else if (wmap) begin
                case (wkind)
                    2'd0: latch_q[wport] <= w_byte_q;
                    2'd1: dir_q[wport] <= w_byte_q;
                    default: opt_q[wport] <= w_byte_q;
                endcase
            end else if (aw_idx_q == `IDX_IRQ_STAT) begin
                irq_stat_q <= (irq_stat_q & ~w_byte_q[3:0]) | evt;
            end else if (aw_idx_q == `IDX_IRQ_MASK) begin
                irq_mask_q <= w_byte_q[3:0];
            end else begin
                s_axi_bresp <= `RESP_SLVERR;
            end
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
        // Read channel
        s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h0, rd_byte};
            s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
        irq <= |(irq_stat_q & irq_mask_q);
    end
end

endmodule // parallel_io_port_block
`default_nettype wire

// File: rtl/pio_map.vh
// Summary of operation
// - Input pin with peripheral output active: latch read returns peripheral output.
// - Output pin with peripheral input: peripheral receives the latched bit.
// - Port B: direction 0 floating input, 1 push-pull output.
// - Option 0 plain input; option 1 input with interrupt on ports A, C, D.
// - Output mode: option 0 open drain, option 1 push-pull.
// - Port C always push-pull out; option selects input interrupt; pins 3:0 high sink.
// - Port F floating in; pins 6:4,1:0 true open drain, 3:2 push-pull; E inputs floating.
// - Without an option bit, direction alone sets the pin configuration.
// - Latch writes always update, even while the pin is an input.
// - Latch address reads return sampled pin levels, except inputs with peripheral output active.
// - Direction bit 0 input, 1 output; all bits read-write.
// - All latch, direction and option registers reset to zero.
// - Registers at consecutive indices 0x00 to 0x12; 0x05 unused.
// - Enabled peripheral function overrides standard port programming.
`ifndef PIO_MAP_VH
`define PIO_MAP_VH
// ============================================================
// Register indices (byte address is four times the index)
`define IDX_A_LATCH 5'h00
`define IDX_A_DIR 5'h01
`define IDX_A_OPT 5'h02
`define IDX_B_LATCH 5'h03
`define IDX_B_DIR 5'h04
`define IDX_UNUSED 5'h05
`define IDX_C_LATCH 5'h06
`define IDX_C_DIR 5'h07
`define IDX_C_OPT 5'h08
`define IDX_D_LATCH 5'h09
`define IDX_D_DIR 5'h0a
`define IDX_D_OPT 5'h0b
`define IDX_E_LATCH 5'h0c
`define IDX_E_DIR 5'h0d
`define IDX_E_OPT 5'h0e
`define IDX_F_LATCH 5'h0f
`define IDX_F_DIR 5'h10
`define IDX_IRQ_STAT 5'h11
`define IDX_IRQ_MASK 5'h12
`define IDX_LAST 5'h12
// ============================================================
// Reset values and fixed pin layouts
`define REG_RESET 8'h00
`define IRQ_RESET 4'h0
`define F_PUSH_PULL 8'h0c
`define C_HIGH_SINK 8'h0f
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// File: verif/pio_chk_assertions.sv
`default_nettype none
// ==========
// Port checker
module pio_chk (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic [1:0] s_axi_bresp,
    // Pins and peripherals
    input wire logic [47:0] pin_in,
    input wire logic [47:0] pin_out,
    input wire logic [47:0] pin_oe,
    input wire logic [47:0] alt_out_en,
    input wire logic [47:0] alt_out_val,
    input wire logic [47:0] alt_out_od,
    input wire logic [23:0] ext_int_level,
    input wire logic [7:0] c_high_sink
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Pin side
    a_sink_fixed: assert property (1 |=> c_high_sink == 8'h0f)
        else $error("high sink map wrong");
    a_f_open_drain: assert property ($past(alt_out_en[47:40]) == 8'h00 |->
        (pin_oe[46:40] & pin_out[46:40] & 7'h73) == 7'h00) else $error("port F drives high");
    a_reset_float: assert property ($rose(aresetn) |-> pin_oe == 48'h0)
        else $error("pins driven after reset");
    a_ext_quiet: assert property ($past(pin_in[7:0]) == 8'h00 &&
        $past(pin_in[7:0], 2) == 8'h00 |-> ext_int_level[7:0] == 8'h00) else $error("ext level");
    a_alt_od_low: assert property ((pin_oe & pin_out & $past(alt_out_en) &
        $past(alt_out_od)) == 48'h0) else $error("alt open drain drives high");
    a_alt_push: assert property ($past(alt_out_en[24]) && !$past(alt_out_od[24]) |->
        pin_oe[24] && pin_out[24] == $past(alt_out_val[24])) else $error("alt value lost");
    // Bus side
    a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_wr_resp: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'b00, 2'b10})
        else $error("bad write response");
    c_refuse: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
    c_ext: cover property ($rose(ext_int_level[0]));
    c_alt: cover property (|(alt_out_en & pin_oe));
endmodule // pio_chk
bind parallel_io_port_block pio_chk chk_u (.*);
`default_nettype wire

// File: verif/pio_board.sv
`default_nettype none
// ==========
// Board circuitry
module pio_board (
    // Device pins
    input wire logic [47:0] pin_out,
    input wire logic [47:0] pin_oe,
    // Level the board drives
    input wire logic [47:0] ext_val,
    // Resolved levels
    output logic [47:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Device wins where it drives
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule // pio_board
`default_nettype wire

// File: verif/testbench.sv
`include "pio_map.vh"
`default_nettype none
// ==========
// Bench top
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [4:0] i; logic [7:0] d; logic [1:0] r;} row_t;
    logic aclk = 0, aresetn = 0, clk_en = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, c_high_sink;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb = 0;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [47:0] pin_in, pin_out, pin_oe, alt_in, ext_val = 0;
    logic [47:0] alt_out_en = 0, alt_out_val = 0, alt_out_od = 0;
    logic [23:0] ext_int_level;
    int n_errors = 0, num_checks = 0, cyc = 0;
    row_t rows[8] = '{'{`IDX_A_DIR, 8'h5a, 2'b00}, '{`IDX_A_OPT, 8'ha5, 2'b00},
        '{`IDX_B_DIR, 8'hc3, 2'b00}, '{`IDX_C_OPT, 8'h3c, 2'b00}, '{`IDX_D_DIR, 8'h81, 2'b00},
        '{`IDX_E_OPT, 8'h7e, 2'b00}, '{`IDX_UNUSED, 8'hff, 2'b10}, '{5'h13, 8'h11, 2'b10}};
    parallel_io_port_block dut_u (.*);
    pio_board board_u (.*);
    // Clock and hang guard
    always #50 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            results();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            n_errors++;
            $display("Error t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [4:0] i, input logic [31:0] d, output logic [1:0] rs);
        @(posedge aclk);
        s_axi_awaddr <= {1'b0, i, 2'b00};
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] i, output logic [31:0] d, output logic [1:0] rs);
        @(posedge aclk);
        s_axi_araddr <= {1'b0, i, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic settle;
        repeat (3) @(posedge aclk);
        #1;
    endtask
    task automatic done(input string s);
        $display("test %0s done", s);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            rd(i[4:0], v, r);
            chk(r, (i == 5 || i > 18) ? 2'b10 : 2'b00);
            if (r === 2'b00) chk(v, 0);
        end
        foreach (rows[k]) begin
            wr(rows[k].i, {24'h0, rows[k].d}, r);
            chk(r, rows[k].r);
            rd(rows[k].i, v, r);
            if (r === 2'b00) chk(v, rows[k].d);
        end
        done("map");
        ext_val <= 48'h3c;
        wr(`IDX_A_LATCH, 32'ha5, r);
        wr(`IDX_A_DIR, 32'h0, r);
        rd(`IDX_A_LATCH, v, r);
        chk(v, 32'h3c);
        wr(`IDX_A_OPT, 32'hff, r);
        wr(`IDX_A_DIR, 32'hff, r);
        settle();
        chk({pin_oe[7:0], pin_out[7:0]}, 16'hffa5);
        wr(`IDX_A_OPT, 32'h0, r);
        settle();
        chk(pin_oe[7:0], 8'h5a);
        rd(`IDX_A_LATCH, v, r);
        chk(v, 32'h24);
        done("port a");
        wr(`IDX_B_LATCH, 32'h5a, r);
        wr(`IDX_B_DIR, 32'hff, r);
        wr(`IDX_C_OPT, 32'h0, r);
        wr(`IDX_C_DIR, 32'hff, r);
        wr(`IDX_F_LATCH, 32'hff, r);
        wr(`IDX_F_DIR, 32'hff, r);
        settle();
        chk({pin_oe[15:8], pin_out[15:8]}, 16'hff5a);
        chk(pin_oe[23:16], 8'hff);
        chk(c_high_sink, 8'h0f);
        chk(pin_oe[46:40], 7'h0c);
        chk(alt_in[15:8], 8'h5a);
        done("fixed ports");
        alt_out_val <= 48'h0000_0100_0000;
        alt_out_en <= 48'h0000_0100_0000;
        wr(`IDX_D_DIR, 32'h0, r);
        settle();
        chk({pin_oe[24], pin_out[24]}, 2'b11);
        alt_out_od <= 48'h0000_0100_0000;
        rd(`IDX_D_LATCH, v, r);
        chk(v, 32'h1);
        chk(pin_oe[24], 1'b0);
        alt_out_en <= 48'h0;
        done("alternate");
        ext_val <= 48'h0;
        wr(`IDX_A_DIR, 32'h0, r);
        wr(`IDX_A_OPT, 32'hff, r);
        wr(`IDX_IRQ_STAT, 32'h7, r);
        wr(`IDX_IRQ_MASK, 32'h1, r);
        ext_val <= 48'hff;
        settle();
        chk({ext_int_level[7:0], irq}, 9'h1ff);
        rd(`IDX_IRQ_STAT, v, r);
        chk(v, 32'h1);
        wr(`IDX_IRQ_STAT, 32'h1, r);
        wr(`IDX_IRQ_MASK, 32'h0, r);
        ext_val <= 48'h0;
        settle();
        ext_val <= 48'hff;
        settle();
        chk(irq, 1'b0);
        ext_val <= 48'h0;
        settle();
        clk_en <= 1'b0;
        ext_val <= 48'hff;
        settle();
        chk(ext_int_level[7:0], 8'h00);
        clk_en <= 1'b1;
        settle();
        chk(ext_int_level[7:0], 8'hff);
        done("interrupt");
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk(pin_oe, 48'h0);
        rd(`IDX_A_DIR, v, r);
        chk(v, 32'h0);
        done("second reset");
        results();
    end
endmodule // testbench
`default_nettype wire
